// ==== verilog/autoneg_adv_defines.svh ====
// Offsets, field positions, reset values and fixed codes of the advertisement register.
// Assumes inclusion by bare name from the design files.
`ifndef AUTONEG_ADV_DEFINES_SVH
`define AUTONEG_ADV_DEFINES_SVH
// Register index of the local ability word; byte address is four times it.
`define LOCAL_ABILITY_IDX      8'h04
// Byte address of the local ability word on the bus.
`define LOCAL_ABILITY_ADDR     12'h010
// Byte address of the control register (converter and gigabit overrides).
`define ADV_CTRL_ADDR          12'h014
// Byte address of the read-only advertised word seen by the engine.
`define ADV_WORD_ADDR          12'h018
// Reset value of the local ability word.
`define LOCAL_ABILITY_RESET    16'h01e1
// Reset value of the control register.
`define ADV_CTRL_RESET         2'h0
// Field positions.
`define MORE_PAGES_POS         15
`define RESERVED_POS           14
`define FAULT_REPORT_POS       13
`define TECH_MSB               12
`define TECH_LSB               5
`define SELECTOR_MSB           4
`define SELECTOR_LSB           0
// Technology bit patterns.
`define TEN_MBIT_HALF          8'h01
`define TEN_MBIT_FULL          8'h02
// Forced technology value while in converter mode.
`define CONVERTER_TECH         8'h60
// The one defined selector value.
`define ETHERNET_SELECTOR_CODE 5'h01
// Control register bit positions.
`define CTRL_CONVERTER_POS     0
`define CTRL_GIGABIT_POS       1
`endif

// ==== verilog/autoneg_adv_pkg.sv ====
// Types shared by the advertisement register files.
// Assumes the defines header is compiled alongside.
package autoneg_adv_pkg;
  // Fields of the sixteen-bit local ability word.
  typedef struct packed {
    logic       more_pages_flag;
    logic       reserved_bit;
    logic       fault_report_bit;
    logic [7:0] technology_bits;
    logic [4:0] message_selector;
  } local_ability_word_type;

  // Overrides that steer what goes out on the link.
  typedef struct packed {
    logic gigabit_adv;
    logic converter_mode;
  } adv_ctrl_type;

  // Bus slave states.
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_DATA
  } bus_state_type;
endpackage

// ==== verilog/adv_word_former.sv ====
// Forms the advertised base-page word from the stored register and overrides.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/10ps
`include "autoneg_adv_defines.svh"

module adv_word_former (
  input  wire logic                                   ref_clk_i,       // Core clock.
  input  wire logic                                   resetn_i,        // Synchronous reset.
  input  wire autoneg_adv_pkg::local_ability_word_type stored_i,       // Software value.
  input  wire autoneg_adv_pkg::adv_ctrl_type           ctrl_i,         // Overrides.
  output logic [15:0]                                  adv_word_o      // Registered word.
);

  // Next advertised word.
  autoneg_adv_pkg::local_ability_word_type nxt_word;
  // Registered advertised word.
  logic [15:0] adv_word_ff;

  // Builds the word, applying each override in turn.
  always_comb begin
    nxt_word = stored_i;
    nxt_word.reserved_bit = 1'b0;
    // Gigabit advertisement needs next pages.
    if (ctrl_i.gigabit_adv) begin
      nxt_word.more_pages_flag = 1'b1;
    end
    // Converter mode pins the technology bits.
    if (ctrl_i.converter_mode) begin
      nxt_word.technology_bits = `CONVERTER_TECH;
    end
    // A reserved selector is never sent; the defined code goes instead.
    if (stored_i.message_selector != `ETHERNET_SELECTOR_CODE) begin
      nxt_word.message_selector = `ETHERNET_SELECTOR_CODE;
    end
  end

  // Registers the word so the output comes from a flip-flop.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      adv_word_ff <= `LOCAL_ABILITY_RESET;
    end else begin
      adv_word_ff <= nxt_word;
    end
  end

  assign adv_word_o = adv_word_ff;

  // A gigabit advertisement shows more pages one cycle later.
  a_gig_more_pages: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ctrl_i.gigabit_adv |=> adv_word_ff[`MORE_PAGES_POS])
    else $error("More-pages flag not forced for gigabit.");

  // Converter mode shows the fixed technology value.
  a_conv_tech: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ctrl_i.converter_mode |=> adv_word_ff[`TECH_MSB:`TECH_LSB] == `CONVERTER_TECH)
    else $error("Technology bits not forced in converter mode.");

  // The selector sent is always the defined code.
  a_sel_legal: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ##1 adv_word_ff[`SELECTOR_MSB:`SELECTOR_LSB] == `ETHERNET_SELECTOR_CODE)
    else $error("Reserved selector transmitted.");

  // Fault bit passes through unchanged.
  a_fault_pass: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    1'b1 |=> adv_word_ff[`FAULT_REPORT_POS] == $past(stored_i.fault_report_bit))
    else $error("Fault report bit not carried.");

endmodule // adv_word_former

// ==== verilog/autoneg_local_ability.sv ====
// What this block does
// - Read-write more-pages flag at bit fifteen.
// - Gigabit advertisement forces more-pages flag.
// - Bit fourteen reserved, reads zero.
// - Read-write fault report bit thirteen.
// - Eight-bit read-write technology field.
// - Lowest bits advertise ten megabit half/full.
// - Converter mode forces technology to 0x60.
// - Five-bit selector; 00001 is Ethernet.
// - Reserved selector values never transmitted.
//
// AHB-Lite slave holding the local ability word and an override register.
// Assumes one AHB-Lite master on ref_clk_i and single whole-word transfers.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "autoneg_adv_defines.svh"

module autoneg_local_ability (
  input  wire logic        ref_clk_i,   // Core clock, 10 MHz.
  input  wire logic        resetn_i,    // Synchronous active-low reset.
  input  wire logic        hsel_i,      // Slave select.
  input  wire logic [11:0] haddr_i,     // Byte address.
  input  wire logic [1:0]  htrans_i,    // Transfer type.
  input  wire logic        hwrite_i,    // Write when high.
  input  wire logic [2:0]  hsize_i,     // Transfer size.
  input  wire logic        hready_i,    // Bus ready.
  input  wire logic [31:0] hwdata_i,    // Write data.
  output logic [31:0]      hrdata_o,    // Read data.
  output logic             hreadyout_o, // Slave ready.
  output logic             hresp_o,     // Response, always OKAY.
  output logic [15:0]      adv_word_o   // Advertised base-page word.
);

  // Stored local ability word and its next value.
  autoneg_adv_pkg::local_ability_word_type ability_ff;
  autoneg_adv_pkg::local_ability_word_type nxt_ability;
  // Override register and its next value.
  autoneg_adv_pkg::adv_ctrl_type ctrl_ff;
  autoneg_adv_pkg::adv_ctrl_type nxt_ctrl;
  // Bus state, latched address phase and read data.
  autoneg_adv_pkg::bus_state_type state_ff;
  autoneg_adv_pkg::bus_state_type nxt_state;
  logic [11:0] addr_ff;
  logic [11:0] nxt_addr;
  logic        write_ff;
  logic        nxt_write;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  // Word shown to the engine, from the former.
  logic [15:0] adv_word;

  // Returns the read value at a byte address; unmapped reads zero.
  function automatic logic [31:0] read_mux(input logic [11:0] addr,
                                           input logic [15:0] abil,
                                           input logic [1:0]  ctrl,
                                           input logic [15:0] adv);
    logic [31:0] val;
    val = 32'h0000_0000;
    unique case (addr)
      `LOCAL_ABILITY_ADDR: val = {16'h0000, abil & ~(16'h0001 << `RESERVED_POS)};
      `ADV_CTRL_ADDR:      val = {30'h0000_0000, ctrl};
      `ADV_WORD_ADDR:      val = {16'h0000, adv};
      default:             val = 32'h0000_0000;
    endcase
    return val;
  endfunction

  // Address phase is taken when selected, ready and non-sequential or sequential.
  logic take;
  assign take = hsel_i & hready_i & htrans_i[1];

  // Computes next bus and register values.
  always_comb begin
    nxt_state   = autoneg_adv_pkg::BUS_IDLE;
    nxt_addr    = addr_ff;
    nxt_write   = write_ff;
    nxt_ability = ability_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_rdata   = rdata_ff;
    // A pending data phase completes now; writes land here.
    if (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff) begin
      if (addr_ff == `LOCAL_ABILITY_ADDR) begin
        nxt_ability.more_pages_flag  = hwdata_i[`MORE_PAGES_POS];
        nxt_ability.reserved_bit     = 1'b0;
        nxt_ability.fault_report_bit = hwdata_i[`FAULT_REPORT_POS];
        nxt_ability.technology_bits  = hwdata_i[`TECH_MSB:`TECH_LSB];
        nxt_ability.message_selector = hwdata_i[`SELECTOR_MSB:`SELECTOR_LSB];
      end else if (addr_ff == `ADV_CTRL_ADDR) begin
        nxt_ctrl.converter_mode = hwdata_i[`CTRL_CONVERTER_POS];
        nxt_ctrl.gigabit_adv    = hwdata_i[`CTRL_GIGABIT_POS];
      end
    end
    // A new address phase is latched; reads are prepared for the data phase.
    if (take) begin
      nxt_state = autoneg_adv_pkg::BUS_DATA;
      nxt_addr  = haddr_i;
      nxt_write = hwrite_i;
      nxt_rdata = read_mux(haddr_i, ability_ff, ctrl_ff, adv_word);
    end
  end

  // Registers bus and register state.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_ff   <= autoneg_adv_pkg::BUS_IDLE;
      addr_ff    <= 12'h000;
      write_ff   <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      ability_ff <= `LOCAL_ABILITY_RESET;
      ctrl_ff    <= `ADV_CTRL_RESET;
    end else begin
      state_ff   <= nxt_state;
      addr_ff    <= nxt_addr;
      write_ff   <= nxt_write;
      rdata_ff   <= nxt_rdata;
      ability_ff <= nxt_ability;
      ctrl_ff    <= nxt_ctrl;
    end
  end

  // Forms the word sent in the next negotiation.
  adv_word_former u_former (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .stored_i   (ability_ff),
    .ctrl_i     (ctrl_ff),
    .adv_word_o (adv_word)
  );

  // Bus answer flops. The slave never stretches a transfer and always answers OKAY.
  // They are flops anyway so that every top-level output leaves from a register.
  logic hreadyout_ff;  // Registered slave ready.
  logic nxt_hreadyout; // Next slave ready.
  logic hresp_ff;      // Registered response.
  logic nxt_hresp;     // Next response.

  // Next values of the answer flops; constant while out of reset.
  always_comb begin
    nxt_hreadyout = 1'b1;
    nxt_hresp     = 1'b0;
  end

  // Registers the answer flops; ready stays high through reset so the bus never hangs.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hreadyout_ff <= nxt_hreadyout;
      hresp_ff     <= nxt_hresp;
    end
  end

  // Outputs from flip-flops; slave never inserts wait states.
  assign hrdata_o    = rdata_ff;
  assign hreadyout_o = hreadyout_ff;
  assign hresp_o     = hresp_ff;
  assign adv_word_o  = adv_word;

  // Stored reserved bit never reads back as one.
  a_res_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !ability_ff.reserved_bit)
    else $error("Reserved bit stored as one.");

  // A write to the ability word stores the more-pages flag.
  a_np_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `LOCAL_ABILITY_ADDR)
    |=> ability_ff.more_pages_flag == $past(hwdata_i[15]))
    else $error("More-pages flag not written.");

  // Technology bits follow the write data.
  a_tech_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `LOCAL_ABILITY_ADDR)
    |=> ability_ff.technology_bits == $past(hwdata_i[12:5]))
    else $error("Technology bits not written.");

  // Selector follows the write data.
  a_sel_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `LOCAL_ABILITY_ADDR)
    |=> ability_ff.message_selector == $past(hwdata_i[4:0]))
    else $error("Selector not written.");

  // Without overrides and with the defined selector stored, the engine sees the stored word one cycle on.
  a_word_pass: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ctrl_ff == 2'b00 && ability_ff.message_selector == 5'h01)
    |=> adv_word_o == $past(ability_ff))
    else $error("Advertised word differs from stored word.");

  // The slave is always ready once out of reset.
  a_ready_high: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    hreadyout_o)
    else $error("Slave ready dropped.");

  // The response is always OKAY.
  a_resp_okay: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !hresp_o)
    else $error("Response not OKAY.");

  // A write to the ability word stores the fault report bit.
  a_fault_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `LOCAL_ABILITY_ADDR)
    |=> ability_ff.fault_report_bit == $past(hwdata_i[13]))
    else $error("Fault report bit not written.");

  // A write to the control register stores the converter override.
  a_conv_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `ADV_CTRL_ADDR)
    |=> ctrl_ff.converter_mode == $past(hwdata_i[0]))
    else $error("Converter override not written.");

  // A write to the control register stores the gigabit override.
  a_gig_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `ADV_CTRL_ADDR)
    |=> ctrl_ff.gigabit_adv == $past(hwdata_i[1]))
    else $error("Gigabit override not written.");

  // The ability word is untouched unless its own data phase writes it.
  a_ability_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `LOCAL_ABILITY_ADDR)
    |=> $stable(ability_ff))
    else $error("Ability word changed without a write.");

  // The control register is untouched unless its own data phase writes it.
  a_ctrl_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_ff == autoneg_adv_pkg::BUS_DATA && write_ff && addr_ff == `ADV_CTRL_ADDR)
    |=> $stable(ctrl_ff))
    else $error("Control register changed without a write.");

  // A taken read of the ability word returns the stored value.
  a_read_ability: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && !hwrite_i && haddr_i == `LOCAL_ABILITY_ADDR)
    |=> hrdata_o == {16'h0000, $past(ability_ff)})
    else $error("Ability word read back wrong.");

  // A taken read of the control register returns the overrides.
  a_read_ctrl: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && !hwrite_i && haddr_i == `ADV_CTRL_ADDR)
    |=> hrdata_o == {30'h0000_0000, $past(ctrl_ff)})
    else $error("Control register read back wrong.");

  // A taken read of the advertised word returns what the engine sees.
  a_read_word: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && !hwrite_i && haddr_i == `ADV_WORD_ADDR)
    |=> hrdata_o == {16'h0000, $past(adv_word)})
    else $error("Advertised word read back wrong.");

  // A taken read of an unmapped address returns zero.
  a_read_unmapped: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && !hwrite_i && haddr_i != `LOCAL_ABILITY_ADDR && haddr_i != `ADV_CTRL_ADDR
     && haddr_i != `ADV_WORD_ADDR)
    |=> hrdata_o == 32'h0000_0000)
    else $error("Unmapped read not zero.");

  // The upper half of the read data is always zero.
  a_read_upper: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    hrdata_o[31:16] == 16'h0000)
    else $error("Upper read data not zero.");

  // Read data stands until the next address phase is taken.
  a_rdata_stand: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !take |=> $stable(hrdata_o))
    else $error("Read data changed without a new transfer.");

  // A taken address phase is followed by its data phase.
  a_data_follows: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take |=> state_ff == autoneg_adv_pkg::BUS_DATA)
    else $error("Data phase missing after address phase.");

  // Without a taken address phase the slave returns to idle.
  a_idle_return: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !take |=> state_ff == autoneg_adv_pkg::BUS_IDLE)
    else $error("Slave left idle without a transfer.");

  // The gigabit override shows as more pages on the output word.
  a_gig_word: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ctrl_ff.gigabit_adv |=> adv_word_o[`MORE_PAGES_POS])
    else $error("Output word lacks forced more-pages flag.");

  // The converter override shows as the fixed technology value on the output word.
  a_conv_word: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ctrl_ff.converter_mode |=> adv_word_o[`TECH_MSB:`TECH_LSB] == `CONVERTER_TECH)
    else $error("Output word lacks forced technology value.");

  // The reserved bit never goes out as one.
  a_word_reserved: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !adv_word_o[`RESERVED_POS])
    else $error("Reserved bit sent as one.");

  // Only the defined selector ever goes out.
  a_word_selector: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    adv_word_o[`SELECTOR_MSB:`SELECTOR_LSB] == `ETHERNET_SELECTOR_CODE)
    else $error("Reserved selector on output word.");

  // Without converter mode the stored technology bits go out unchanged.
  a_tech_pass: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !ctrl_ff.converter_mode
    |=> adv_word_o[`TECH_MSB:`TECH_LSB] == $past(ability_ff.technology_bits))
    else $error("Technology bits not carried.");

  // Without the gigabit override the stored more-pages flag goes out unchanged.
  a_np_pass: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !ctrl_ff.gigabit_adv
    |=> adv_word_o[`MORE_PAGES_POS] == $past(ability_ff.more_pages_flag))
    else $error("More-pages flag not carried.");

  // The fault report bit goes out unchanged under every override.
  a_fault_word: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    1'b1 |=> adv_word_o[`FAULT_REPORT_POS] == $past(ability_ff.fault_report_bit))
    else $error("Fault report bit not sent.");

endmodule // autoneg_local_ability

// ==== tb/link_partner_model.sv ====
// Model of the remote partner that receives the advertised base page.
// Assumes the advertised word comes from logic on the same core clock.
`timescale 1ns/10ps

module link_partner_model (
  input  wire logic        ref_clk_i,  // Core clock.
  input  wire logic        resetn_i,   // Synchronous active-low reset.
  input  wire logic [15:0] adv_word_i, // Base page offered by the device.
  output logic      [15:0] rx_word_o   // Base page as last received.
);
  logic [15:0] rx_word_ff; // Last page taken from the link.
  logic [15:0] nxt_rx_word; // Page to take at the next edge.

  // Take the offered page whole each cycle; nothing is received in reset.
  always_comb begin
    nxt_rx_word = resetn_i ? adv_word_i : 16'h0000;
  end

  // Register the received page.
  always_ff @(posedge ref_clk_i) begin
    rx_word_ff <= nxt_rx_word;
  end

  assign rx_word_o = rx_word_ff; // The partner's view of the page.
endmodule // link_partner_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the advertisement register over AHB-Lite.
// Assumes a zero-wait slave and the link partner model beside it.
`timescale 1ns/10ps

module tb_top;
  logic        clk = 1'b0;     // Core clock, 100 ns period.
  logic        rstn = 1'b0;    // Active-low reset.
  logic        hsel = 1'b0;    // Slave select.
  logic [11:0] haddr = 12'h000; // Byte address.
  logic [1:0]  htrans = 2'h0;  // Transfer type.
  logic        hwrite = 1'b0;  // Write when high.
  logic [2:0]  hsize = 3'h2;   // Whole word.
  logic [31:0] hwdata = 32'h0; // Write data.
  logic [31:0] hrdata;         // Read data.
  logic        hreadyout;      // Slave ready, also the bus ready.
  logic        hresp;          // Slave response.
  logic [15:0] adv_word;       // Advertised word.
  logic [15:0] rx_word;        // Word seen by the partner.
  int          error_cnt = 0;  // Mismatches.
  int          checked = 0;    // Comparisons.
  logic [31:0] seed = 32'h00f81860; // Random state.

  autoneg_local_ability autoneg_local_ability_i (.ref_clk_i(clk), .resetn_i(rstn),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .adv_word_o(adv_word));
  link_partner_model link_partner_model_i (.ref_clk_i(clk), .resetn_i(rstn),
    .adv_word_i(adv_word), .rx_word_o(rx_word));

  // Free-running core clock.
  initial begin
    forever #50 clk = ~clk;
  end

  // Next value of the random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected advertised word from the stored value and the overrides.
  function automatic logic [15:0] exp_adv(input logic [15:0] ab, input logic [1:0] c);
    exp_adv = ab & 16'hbfff;
    if (c[1]) exp_adv[15] = 1'b1; // Gigabit advertisement forces more pages.
    if (c[0]) exp_adv[12:5] = 8'h60; // Converter mode forces the technology field.
    if (exp_adv[4:0] !== 5'h01) exp_adv[4:0] = 5'h01; // Reserved selectors never go out.
  endfunction

  // Counts a comparison and reports a mismatch.
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; waits for ready in each phase.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    check_val({31'h0, hresp}, 32'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // Main sequence: reset values, then corner and random words under every override.
  initial begin
    logic [31:0] r;
    logic [15:0] v;
    logic [15:0] corner[5];
    corner = '{16'hffff, 16'h0000, 16'h2001, 16'h0021, 16'h0041};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check_val({16'h0, adv_word}, 32'h01e1);
    bus(1'b0, 12'h010, 32'h0, r);
    check_val(r, 32'h01e1);
    bus(1'b0, 12'h014, 32'h0, r);
    check_val(r, 32'h0);
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      v = ((i < 5) ? corner[i] : seed[15:0]) & 16'hbfff; // Software writes bit 14 as zero.
      bus(1'b1, 12'h010, {16'h0, v}, r);
      bus(1'b1, 12'h014, {30'h0, i[1:0]}, r);
      bus(1'b1, 12'h020, 32'hffff_ffff, r); // Unmapped write is ignored.
      repeat (3) @(posedge clk);
      check_val({16'h0, adv_word}, {16'h0, exp_adv(v, i[1:0])});
      check_val({16'h0, rx_word}, {16'h0, exp_adv(v, i[1:0])});
      bus(1'b0, 12'h010, 32'h0, r);
      check_val(r, {16'h0, v & 16'hbfff});
      bus(1'b0, 12'h018, 32'h0, r);
      check_val(r, {16'h0, exp_adv(v, i[1:0])});
      bus(1'b0, 12'h020, 32'h0, r);
      check_val(r, 32'h0);
    end
    give_verdict();
  end
endmodule // tb_top
